// ==== src/mups_pkg.sv ====
package mups_pkg;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_SEG_SEL = 4'h0;
    localparam logic [3:0] ADDR_FUNC = 4'h1;
    localparam logic [3:0] ADDR_CKOUT = 4'h2;
    localparam logic [3:0] ADDR_TMUX = 4'h3;
    localparam logic [3:0] ADDR_GIO_OUT = 4'h4;
    localparam logic [3:0] ADDR_GIO_DIR = 4'h5;
    localparam logic [3:0] ADDR_STATUS = 4'h6;
    localparam logic [3:0] ADDR_IRQ_CLR = 4'h7;
    localparam logic [3:0] ADDR_IRQ_EN = 4'h8;
    localparam logic [3:0] ADDR_PADS = 4'h9;

    // ------------------------------------------------------------
    // field positions of the function register
    // ------------------------------------------------------------
    localparam int FUNC_EEPROM = 0;
    localparam int FUNC_PULSE = 1;
    localparam int FUNC_RX_SEL = 2;
    localparam int FUNC_TX_LO = 3;
    localparam int FUNC_VREF_CAL = 5;
    localparam int FUNC_W = 6;

    // tx pad modes (two bits at FUNC_TX_LO)
    localparam logic [1:0] TX_GIO = 2'h0;
    localparam logic [1:0] TX_UART = 2'h1;
    localparam logic [1:0] TX_WATT = 2'h2;
    localparam logic [1:0] TX_VAR = 2'h3;

    // clock output select codes
    localparam logic [1:0] CK_SEG = 2'h0;

    // status bits
    localparam int ST_FAULT = 0;
    localparam int ST_RECOVER = 1;
    localparam int ST_W = 2;

    // ------------------------------------------------------------
    // widths and reset values
    // ------------------------------------------------------------
    localparam int NSHARED = 8;
    localparam int NGIO = 12;
    localparam int NTEST = 32;
    localparam logic [7:0] SEG_SEL_RST = 8'h00;
    localparam logic [5:0] FUNC_RST = 6'h00;
    localparam logic [11:0] GIO_RST = 12'h000;

endpackage : mups_pkg

// ==== src/mups_pfail.sv ====
`timescale 1ns/10ps

module mups_pfail (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic powerfail_sense,
    output logic comp_out_q,
    output logic fault_pulse_q,
    output logic recover_pulse_q,
    output logic battery_mode_q
);

    // comparator result is already digital; one stage for edge detection
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            comp_out_q <= 1'b1;
        end else begin
            comp_out_q <= powerfail_sense;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            fault_pulse_q <= 1'b0;
            recover_pulse_q <= 1'b0;
            battery_mode_q <= 1'b0;
        end else begin
            fault_pulse_q <= comp_out_q && !powerfail_sense;
            recover_pulse_q <= !comp_out_q && powerfail_sense;
            battery_mode_q <= !powerfail_sense;
        end
    end

    property p_fault;
        @(posedge clk_sys) disable iff (!rst_n)
        $fell(comp_out_q) |-> fault_pulse_q && battery_mode_q;
    endproperty
    a_fault: assert property (p_fault)
        else $error("fall of comparator did not flag fault");

endmodule : mups_pfail

// ==== src/mups_top.sv ====
`timescale 1ns/10ps

// Behaviour
// - emulator pads become segments 32,33,38 when disabled
// - emulator enabled: pads carry emulator port
// - shared pads 24..31 each segment or gio
// - eeprom mode: gio4 clock, gio5 data
// - pulse mode: gio6 watt, gio7 var
// - clock test pad: pll clock or segment
// - test pad drives signal chosen by select
// - receive pad selectable uart or gio
// - transmit pad: uart, watt, var or gio
// - sense low flags fault, battery mode
// - four common lines drive lcd backplanes
module mups_top (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    output logic irq,
    input wire logic emulator_enable_pin,
    input wire logic emu_reset_in,
    input wire logic emu_clock_in,
    input wire logic emu_data_in,
    input wire logic emu_data_oe_n,
    input wire logic [3:0] lcd_common_in,
    input wire logic [41:0] lcd_seg_in,
    input wire logic pll_clock,
    input wire logic [mups_pkg::NTEST-1:0] test_sigs,
    input wire logic eeprom_sck,
    input wire logic eeprom_sda_out,
    input wire logic eeprom_sda_oe_n,
    input wire logic watt_energy_pulse,
    input wire logic var_energy_pulse,
    input wire logic serial1_transmit,
    input wire logic powerfail_sense,
    output logic serial1_receive,
    output logic eeprom_sda_in,
    output logic [mups_pkg::NGIO-1:0] general_io_in,
    input wire logic [mups_pkg::NGIO-1:0] pad_gio_in,
    output logic [mups_pkg::NGIO-1:0] pad_gio_out,
    output logic [mups_pkg::NGIO-1:0] pad_gio_oe_n,
    output logic [mups_pkg::NSHARED-1:0] lcd_segment_driver,
    output logic [mups_pkg::NSHARED-1:0] lcd_seg_en,
    output logic [3:0] lcd_common_line,
    output logic emu_reset_pad,
    output logic emu_clock_pad,
    output logic emu_data_pad,
    output logic emu_data_pad_oe_n,
    input wire logic emu_data_pad_in,
    output logic [2:0] emu_seg_out,
    output logic emu_seg_mode,
    output logic pll_clock_test_pad,
    output logic test_mux_pad,
    output logic battery_mode,
    output logic vref_pad_en
);
    default clocking cb_sys @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    logic [mups_pkg::NSHARED-1:0] seg_sel_q;
    logic [mups_pkg::FUNC_W-1:0] func_q;
    logic [1:0] clock_out_select_q;
    logic [4:0] test_mux_select_q;
    logic [mups_pkg::NGIO-1:0] gio_out_q;
    logic [mups_pkg::NGIO-1:0] gio_dir_q;
    logic [mups_pkg::ST_W-1:0] status_q;
    logic [mups_pkg::ST_W-1:0] irq_en_q;
    logic comp_out;
    logic fault_pulse;
    logic recover_pulse;
    logic batt_q;

    function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
        hit = (a == off);
    endfunction : hit

    // writes land here; pads follow one edge later from output flops
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            seg_sel_q <= mups_pkg::SEG_SEL_RST;
            func_q <= mups_pkg::FUNC_RST;
            clock_out_select_q <= mups_pkg::CK_SEG;
            test_mux_select_q <= 5'h00;
            gio_out_q <= mups_pkg::GIO_RST;
            gio_dir_q <= mups_pkg::GIO_RST;
            irq_en_q <= '0;
        end else if (reg_wr) begin
            if (hit(reg_addr, mups_pkg::ADDR_SEG_SEL)) seg_sel_q <= reg_wdata[7:0];
            if (hit(reg_addr, mups_pkg::ADDR_FUNC)) func_q <= reg_wdata[5:0];
            if (hit(reg_addr, mups_pkg::ADDR_CKOUT)) clock_out_select_q <= reg_wdata[1:0];
            if (hit(reg_addr, mups_pkg::ADDR_TMUX)) test_mux_select_q <= reg_wdata[4:0];
            if (hit(reg_addr, mups_pkg::ADDR_GIO_OUT)) gio_out_q <= reg_wdata[11:0];
            // direction bit 1 = output; unused pads are set so by firmware
            if (hit(reg_addr, mups_pkg::ADDR_GIO_DIR)) gio_dir_q <= reg_wdata[11:0];
            if (hit(reg_addr, mups_pkg::ADDR_IRQ_EN)) irq_en_q <= reg_wdata[1:0];
        end
    end

    // ------------------------------------------------------------
    // power-fail comparator
    // ------------------------------------------------------------
    mups_pfail u_pfail (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .powerfail_sense(powerfail_sense),
        .comp_out_q(comp_out),
        .fault_pulse_q(fault_pulse),
        .recover_pulse_q(recover_pulse),
        .battery_mode_q(batt_q)
    );

    // set wins over clear so an event in the clear cycle survives
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            status_q <= '0;
        end else begin
            status_q <= (status_q
                & ~((reg_wr && hit(reg_addr, mups_pkg::ADDR_IRQ_CLR)) ? reg_wdata[1:0] : 2'h0))
                | {recover_pulse, fault_pulse};
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(status_q & irq_en_q);
        end
    end

    // ------------------------------------------------------------
    // read port
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            case (reg_addr)
                mups_pkg::ADDR_SEG_SEL: reg_rdata <= {8'h00, seg_sel_q};
                mups_pkg::ADDR_FUNC: reg_rdata <= {10'h000, func_q};
                mups_pkg::ADDR_CKOUT: reg_rdata <= {14'h0000, clock_out_select_q};
                mups_pkg::ADDR_TMUX: reg_rdata <= {11'h000, test_mux_select_q};
                mups_pkg::ADDR_GIO_OUT: reg_rdata <= {4'h0, gio_out_q};
                mups_pkg::ADDR_GIO_DIR: reg_rdata <= {4'h0, gio_dir_q};
                mups_pkg::ADDR_STATUS: reg_rdata <= {14'h0000, status_q};
                mups_pkg::ADDR_IRQ_EN: reg_rdata <= {14'h0000, irq_en_q};
                mups_pkg::ADDR_PADS: reg_rdata <= {1'b0, emu_data_pad_in, batt_q, comp_out,
                    pad_gio_in};
                default: reg_rdata <= 16'h0000;
            endcase
        end else begin
            reg_rdata <= 16'h0000;
        end
    end

    // ------------------------------------------------------------
    // shared segment / gio pads
    // ------------------------------------------------------------
    wire logic eep = func_q[mups_pkg::FUNC_EEPROM];
    wire logic pls = func_q[mups_pkg::FUNC_PULSE];
    wire logic [1:0] tx_mode = func_q[mups_pkg::FUNC_TX_LO+1:mups_pkg::FUNC_TX_LO];

    // all pad drivers registered so select changes never glitch
    genvar gi;
    generate
        for (gi = 0; gi < mups_pkg::NSHARED; gi++) begin : g_shared
            localparam int IO = gi + 4;
            always_ff @(posedge clk_sys) begin
                if (!rst_n) begin
                    lcd_segment_driver[gi] <= 1'b0;
                    lcd_seg_en[gi] <= 1'b0;
                    pad_gio_out[IO] <= 1'b0;
                    pad_gio_oe_n[IO] <= 1'b1;
                end else begin
                    lcd_segment_driver[gi] <= lcd_seg_in[gi+24];
                    lcd_seg_en[gi] <= seg_sel_q[gi];
                    if (seg_sel_q[gi]) begin
                        pad_gio_out[IO] <= 1'b0;
                        pad_gio_oe_n[IO] <= 1'b1;
                    end else if (eep && IO == 4) begin
                        pad_gio_out[IO] <= eeprom_sck;
                        pad_gio_oe_n[IO] <= 1'b0;
                    end else if (eep && IO == 5) begin
                        pad_gio_out[IO] <= eeprom_sda_out;
                        pad_gio_oe_n[IO] <= eeprom_sda_oe_n;
                    end else if (pls && IO == 6) begin
                        pad_gio_out[IO] <= watt_energy_pulse;
                        pad_gio_oe_n[IO] <= 1'b0;
                    end else if (pls && IO == 7) begin
                        pad_gio_out[IO] <= var_energy_pulse;
                        pad_gio_oe_n[IO] <= 1'b0;
                    end else begin
                        pad_gio_out[IO] <= gio_out_q[IO];
                        pad_gio_oe_n[IO] <= !gio_dir_q[IO];
                    end
                end
            end
        end
    endgenerate

    // pads 0..3: 1 is receive, 2 is transmit, 0 and 3 plain gio
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            pad_gio_out[3:0] <= 4'h0;
            pad_gio_oe_n[3:0] <= 4'hF;
        end else begin
            pad_gio_out[0] <= gio_out_q[0];
            pad_gio_oe_n[0] <= !gio_dir_q[0];
            pad_gio_out[3] <= gio_out_q[3];
            pad_gio_oe_n[3] <= !gio_dir_q[3];
            pad_gio_out[1] <= func_q[mups_pkg::FUNC_RX_SEL] ? 1'b0 : gio_out_q[1];
            pad_gio_oe_n[1] <= func_q[mups_pkg::FUNC_RX_SEL] | !gio_dir_q[1];
            case (tx_mode)
                mups_pkg::TX_UART: pad_gio_out[2] <= serial1_transmit;
                mups_pkg::TX_WATT: pad_gio_out[2] <= watt_energy_pulse;
                mups_pkg::TX_VAR: pad_gio_out[2] <= var_energy_pulse;
                default: pad_gio_out[2] <= gio_out_q[2];
            endcase
            pad_gio_oe_n[2] <= (tx_mode == mups_pkg::TX_GIO) ? !gio_dir_q[2] : 1'b0;
        end
    end

    // inputs back to the core
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            serial1_receive <= 1'b1;
            eeprom_sda_in <= 1'b1;
            general_io_in <= mups_pkg::GIO_RST;
        end else begin
            // ir photo-detector works here as a plain level
            serial1_receive <= func_q[mups_pkg::FUNC_RX_SEL] ? pad_gio_in[1] : 1'b1;
            eeprom_sda_in <= pad_gio_in[5];
            general_io_in <= pad_gio_in;
        end
    end

    // ------------------------------------------------------------
    // emulator pads, clock test, test mux, lcd commons
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            emu_reset_pad <= 1'b0;
            emu_clock_pad <= 1'b0;
            emu_data_pad <= 1'b0;
            emu_data_pad_oe_n <= 1'b1;
            emu_seg_out <= 3'h0;
            emu_seg_mode <= 1'b1;
        end else begin
            emu_seg_mode <= !emulator_enable_pin;
            emu_seg_out <= {lcd_seg_in[38], lcd_seg_in[33], lcd_seg_in[32]};
            emu_reset_pad <= emulator_enable_pin & emu_reset_in;
            emu_clock_pad <= emulator_enable_pin & emu_clock_in;
            emu_data_pad <= emulator_enable_pin & emu_data_in;
            emu_data_pad_oe_n <= !emulator_enable_pin | emu_data_oe_n;
        end
    end

    // pll clock is retimed; only usable for test clocks below half the 10 MHz clk_sys
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            pll_clock_test_pad <= 1'b0;
            test_mux_pad <= 1'b0;
            lcd_common_line <= 4'h0;
            battery_mode <= 1'b0;
            vref_pad_en <= 1'b1;
        end else begin
            pll_clock_test_pad <= (clock_out_select_q == mups_pkg::CK_SEG)
                ? lcd_seg_in[19] : pll_clock;
            test_mux_pad <= test_sigs[test_mux_select_q];
            lcd_common_line <= lcd_common_in;
            battery_mode <= batt_q;
            vref_pad_en <= !func_q[mups_pkg::FUNC_VREF_CAL];
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_emu_off;
        !emulator_enable_pin;
    endsequence
    property p_emu_seg;
        s_emu_off ##1 1 |-> emu_seg_mode && emu_data_pad_oe_n;
    endproperty
    a_emu_seg: assert property (p_emu_seg)
        else $error("emulator pads not in segment mode");
    property p_emu_on;
        emulator_enable_pin |=> emu_clock_pad == $past(emu_clock_in);
    endproperty
    a_emu_on: assert property (p_emu_on)
        else $error("emulator clock not passed");
    property p_seg_en;
        1 |=> lcd_seg_en[0] == $past(seg_sel_q[0]) && (!lcd_seg_en[0] || pad_gio_oe_n[4]);
    endproperty
    a_seg_en: assert property (p_seg_en)
        else $error("segment select not applied");
    property p_eep;
        eep && !seg_sel_q[0] |=> pad_gio_out[4] == $past(eeprom_sck) && !pad_gio_oe_n[4];
    endproperty
    a_eep: assert property (p_eep)
        else $error("eeprom clock not on gio4");
    property p_pulse;
        pls && !seg_sel_q[2] |=> pad_gio_out[6] == $past(watt_energy_pulse);
    endproperty
    a_pulse: assert property (p_pulse)
        else $error("watt pulse not on gio6");
    property p_tmux;
        1 |=> test_mux_pad == $past(test_sigs[test_mux_select_q]);
    endproperty
    a_tmux: assert property (p_tmux)
        else $error("test mux output wrong");
    property p_tx;
        tx_mode == mups_pkg::TX_UART |=> pad_gio_out[2] == $past(serial1_transmit)
            && !pad_gio_oe_n[2];
    endproperty
    a_tx: assert property (p_tx)
        else $error("uart transmit not on gio2");
    property p_vref;
        func_q[mups_pkg::FUNC_VREF_CAL] |=> !vref_pad_en;
    endproperty
    a_vref: assert property (p_vref)
        else $error("reference pad not disabled");
    property p_irq;
        fault_pulse && irq_en_q[0] |=> ##1 irq;
    endproperty
    a_irq: assert property (p_irq)
        else $error("fault did not raise interrupt");

endmodule : mups_top

// ==== dv/mups_pad_model.sv ====
`timescale 1ns/10ps

module mups_pad_model (
    input wire logic clk_sys,
    input wire logic [mups_pkg::NGIO-1:0] pad_gio_out,
    input wire logic [mups_pkg::NGIO-1:0] pad_gio_oe_n,
    input wire logic [mups_pkg::NGIO-1:0] ext_val,
    input wire logic [mups_pkg::NGIO-1:0] ext_en,
    input wire logic emu_data_pad,
    input wire logic emu_data_pad_oe_n,
    output logic [mups_pkg::NGIO-1:0] pad_gio_in,
    output logic emu_data_pad_in
);
    // ----------
    // pad levels
    // ----------
    // a released pad nobody holds wanders every cycle, so a stale level never passes for valid
    logic wander_q = 1'b0;

    always @(posedge clk_sys) begin
        wander_q <= ~wander_q;
    end

    always_comb begin
        for (int j = 0; j < mups_pkg::NGIO; j++) begin
            pad_gio_in[j] = !pad_gio_oe_n[j] ? pad_gio_out[j] :
                            ext_en[j] ? ext_val[j] : wander_q ^ j[0];
        end
        emu_data_pad_in = !emu_data_pad_oe_n ? emu_data_pad : wander_q;
    end
endmodule : mups_pad_model

// ==== dv/tb_top.sv ====
`timescale 1ns/10ps

module tb_top;
    // ----------
    // signals
    // ----------
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic emulator_enable_pin = 1'b0;
    logic emu_reset_in = 1'b0, emu_clock_in = 1'b0, emu_data_in = 1'b0, emu_data_oe_n = 1'b1;
    logic [3:0] lcd_common_in = 4'h0;
    logic [41:0] lcd_seg_in = 42'h0;
    logic [31:0] test_sigs = 32'h0;
    logic pll_clock = 1'b0, eeprom_sck = 1'b0, eeprom_sda_out = 1'b0, eeprom_sda_oe_n = 1'b1;
    logic watt_energy_pulse = 1'b0, var_energy_pulse = 1'b0, serial1_transmit = 1'b0;
    logic powerfail_sense = 1'b1;
    logic [11:0] ext_val = 12'h000, ext_en = 12'hFFF;
    logic [15:0] reg_rdata;
    logic irq, serial1_receive, eeprom_sda_in, emu_reset_pad, emu_clock_pad, emu_data_pad;
    logic emu_data_pad_oe_n, emu_data_pad_in, emu_seg_mode, pll_clock_test_pad, test_mux_pad;
    logic battery_mode, vref_pad_en;
    logic [11:0] general_io_in, pad_gio_in, pad_gio_out, pad_gio_oe_n, c_out, c_dir;
    logic [7:0] lcd_segment_driver, lcd_seg_en, c_seg;
    logic [3:0] lcd_common_line;
    logic [2:0] emu_seg_out;
    logic [5:0] c_func;
    logic [4:0] c_tmux;
    logic [1:0] c_ck;
    integer seed = 32'hE4568FD4;
    int miscompares = 0;
    int compares = 0;
    int cycles = 0;

    always #50 clk_sys = ~clk_sys;

    mups_top i_dut (
        .clk_sys, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq,
        .emulator_enable_pin, .emu_reset_in, .emu_clock_in, .emu_data_in, .emu_data_oe_n,
        .lcd_common_in, .lcd_seg_in, .pll_clock, .test_sigs, .eeprom_sck, .eeprom_sda_out,
        .eeprom_sda_oe_n, .watt_energy_pulse, .var_energy_pulse, .serial1_transmit,
        .powerfail_sense, .serial1_receive, .eeprom_sda_in, .general_io_in, .pad_gio_in,
        .pad_gio_out, .pad_gio_oe_n, .lcd_segment_driver, .lcd_seg_en, .lcd_common_line,
        .emu_reset_pad, .emu_clock_pad, .emu_data_pad, .emu_data_pad_oe_n, .emu_data_pad_in,
        .emu_seg_out, .emu_seg_mode, .pll_clock_test_pad, .test_mux_pad, .battery_mode,
        .vref_pad_en
    );

    mups_pad_model i_pads (
        .clk_sys, .pad_gio_out, .pad_gio_oe_n, .ext_val, .ext_en, .emu_data_pad,
        .emu_data_pad_oe_n, .pad_gio_in, .emu_data_pad_in
    );

    // ----------
    // helpers
    // ----------
    task automatic conclude();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : conclude

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            conclude();
        end
    end

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rdc(input logic [3:0] a, input logic [15:0] mask, input logic [15:0] exp);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        chk("reg_rdata", 32'(reg_rdata & mask), 32'(exp));
    endtask : rdc

    task automatic scramble(input logic emu);
        @(posedge clk_sys);
        emulator_enable_pin <= emu;
        {emu_reset_in, emu_clock_in, emu_data_in, emu_data_oe_n} <= 4'($random(seed));
        lcd_common_in <= 4'($random(seed));
        lcd_seg_in <= {10'($random(seed)), 32'($random(seed))};
        test_sigs <= 32'($random(seed));
        {pll_clock, eeprom_sck, eeprom_sda_out, eeprom_sda_oe_n} <= 4'($random(seed));
        {watt_energy_pulse, var_energy_pulse, serial1_transmit} <= 3'($random(seed));
        ext_val <= 12'($random(seed));
        ext_en <= 12'($random(seed));
    endtask : scramble

    // {oe_n, out} expected on general pad j
    function automatic logic [1:0] exp_gio(input int j);
        logic [1:0] m;
        m = c_func[mups_pkg::FUNC_TX_LO +: 2];
        if (j >= 4 && c_seg[j-4]) return 2'b10;
        if (c_func[mups_pkg::FUNC_EEPROM] && j == 4) return {1'b0, eeprom_sck};
        if (c_func[mups_pkg::FUNC_EEPROM] && j == 5) return {eeprom_sda_oe_n, eeprom_sda_out};
        if (c_func[mups_pkg::FUNC_PULSE] && j == 6) return {1'b0, watt_energy_pulse};
        if (c_func[mups_pkg::FUNC_PULSE] && j == 7) return {1'b0, var_energy_pulse};
        if (c_func[mups_pkg::FUNC_RX_SEL] && j == 1) return 2'b10;
        if (j == 2 && m != mups_pkg::TX_GIO) return {1'b0, m == mups_pkg::TX_UART ?
            serial1_transmit : m == mups_pkg::TX_WATT ? watt_energy_pulse : var_energy_pulse};
        return {!c_dir[j], c_out[j]};
    endfunction : exp_gio

    // {known, level}; a released pad nobody holds is skipped
    function automatic logic [1:0] pad_lvl(input int j);
        logic [1:0] e;
        e = exp_gio(j);
        if (!e[1]) return {1'b1, e[0]};
        return {ext_en[j], ext_val[j]};
    endfunction : pad_lvl

    task automatic apply_cfg();
        wr(mups_pkg::ADDR_SEG_SEL, 16'(c_seg));
        wr(mups_pkg::ADDR_FUNC, 16'(c_func));
        wr(mups_pkg::ADDR_CKOUT, 16'(c_ck));
        wr(mups_pkg::ADDR_TMUX, 16'(c_tmux));
        wr(mups_pkg::ADDR_GIO_OUT, 16'(c_out));
        wr(mups_pkg::ADDR_GIO_DIR, 16'(c_dir));
        repeat (4) @(posedge clk_sys);
        #1;
    endtask : apply_cfg

    task automatic check_all();
        logic [1:0] e;
        logic [1:0] p;
        for (int j = 0; j < mups_pkg::NGIO; j++) begin
            e = exp_gio(j);
            p = pad_lvl(j);
            chk("gio_oe_n", 32'(pad_gio_oe_n[j]), 32'(e[1]));
            if (!e[1]) chk("gio_out", 32'(pad_gio_out[j]), 32'(e[0]));
            if (p[1]) chk("gio_in", 32'(general_io_in[j]), 32'(p[0]));
        end
        for (int i = 0; i < mups_pkg::NSHARED; i++) begin
            if (c_seg[i]) chk("seg", 32'(lcd_segment_driver[i]), 32'(lcd_seg_in[24+i]));
        end
        chk("seg_en", 32'(lcd_seg_en), 32'(c_seg));
        chk("commons", 32'(lcd_common_line), 32'(lcd_common_in));
        chk("emu_mode", 32'(emu_seg_mode), 32'(!emulator_enable_pin));
        if (!emulator_enable_pin) chk("emu_seg", 32'(emu_seg_out),
            32'({lcd_seg_in[38], lcd_seg_in[33], lcd_seg_in[32]}));
        else chk("emu_pads", 32'({emu_reset_pad, emu_clock_pad, emu_data_pad, emu_data_pad_oe_n}),
            32'({emu_reset_in, emu_clock_in, emu_data_in, emu_data_oe_n}));
        chk("ck_pad", 32'(pll_clock_test_pad),
            32'(c_ck == mups_pkg::CK_SEG ? lcd_seg_in[19] : pll_clock));
        chk("tmux", 32'(test_mux_pad), 32'(test_sigs[c_tmux]));
        chk("vref", 32'(vref_pad_en), 32'(!c_func[mups_pkg::FUNC_VREF_CAL]));
        p = pad_lvl(1);
        if (c_func[mups_pkg::FUNC_RX_SEL] && p[1]) chk("rx", 32'(serial1_receive), 32'(p[0]));
        p = pad_lvl(5);
        if (c_func[mups_pkg::FUNC_EEPROM] && p[1]) chk("sda", 32'(eeprom_sda_in), 32'(p[0]));
        if (emulator_enable_pin && !emu_data_oe_n)
            rdc(mups_pkg::ADDR_PADS, 16'h4000, 16'(emu_data_in) << 14);
        rdc(mups_pkg::ADDR_SEG_SEL, 16'hFFFF, 16'(c_seg));
        rdc(mups_pkg::ADDR_FUNC, 16'hFFFF, 16'(c_func));
        rdc(mups_pkg::ADDR_TMUX, 16'hFFFF, 16'(c_tmux));
        rdc(mups_pkg::ADDR_GIO_DIR, 16'hFFFF, 16'(c_dir));
    endtask : check_all

    // ----------
    // tests
    // ----------
    initial begin
        repeat (8) @(posedge clk_sys);
        rst_n <= 1'b1;
        for (int a = 0; a < 16; a++) begin
            if (a != 7 && a != 9) rdc(4'(a), 16'hFFFF, 16'h0000);
        end
        chk("oe_rst", 32'(pad_gio_oe_n), 32'(12'hFFF));
        chk("vref_rst", 32'(vref_pad_en), 32'(1'b1));
        $display("test reset done");
        for (int n = 0; n < 40; n++) begin
            {c_seg, c_func, c_ck, c_tmux} = 21'($random(seed));
            {c_out, c_dir} = 24'($random(seed));
            scramble(1'($random(seed)));
            apply_cfg();
            check_all();
        end
        $display("test random done");
        // every tx and clock mode; the last one also makes segments win over eeprom and pulse
        for (int m = 0; m < 4; m++) begin
            c_seg = m == 3 ? 8'hFF : 8'h00;
            c_func = 6'h07 | 6'(m << mups_pkg::FUNC_TX_LO);
            c_ck = 2'(m);
            c_dir = 12'hFFF;
            scramble(m[0]);
            apply_cfg();
            check_all();
        end
        $display("test modes done");
        for (int k = 0; k < mups_pkg::NTEST; k++) begin
            c_tmux = 5'(k);
            scramble(1'b0);
            apply_cfg();
            check_all();
        end
        $display("test tmux done");
        c_func = c_func ^ 6'h20;
        wr(mups_pkg::ADDR_FUNC, 16'(c_func));
        #1;
        chk("vref_hold", 32'(vref_pad_en), 32'(c_func[mups_pkg::FUNC_VREF_CAL]));
        @(posedge clk_sys);
        #1;
        chk("vref_next", 32'(vref_pad_en), 32'(!c_func[mups_pkg::FUNC_VREF_CAL]));
        $display("test timing done");
        wr(mups_pkg::ADDR_IRQ_EN, 16'h0000);
        @(posedge clk_sys);
        powerfail_sense <= 1'b0;
        repeat (6) @(posedge clk_sys);
        #1;
        chk("irq_masked", 32'(irq), 32'(1'b0));
        chk("battery", 32'(battery_mode), 32'(1'b1));
        rdc(mups_pkg::ADDR_STATUS, 16'hFFFF, 16'h0001);
        rdc(mups_pkg::ADDR_PADS, 16'h3000, 16'h2000);
        wr(mups_pkg::ADDR_STATUS, 16'h0000);
        wr(mups_pkg::ADDR_IRQ_EN, 16'h0001);
        repeat (3) @(posedge clk_sys);
        #1;
        chk("irq_set", 32'(irq), 32'(1'b1));
        rdc(mups_pkg::ADDR_STATUS, 16'hFFFF, 16'h0001);
        wr(mups_pkg::ADDR_IRQ_CLR, 16'h0001);
        @(posedge clk_sys);
        powerfail_sense <= 1'b1;
        repeat (6) @(posedge clk_sys);
        #1;
        chk("irq_clear", 32'(irq), 32'(1'b0));
        rdc(mups_pkg::ADDR_STATUS, 16'hFFFF, 16'h0002);
        rdc(mups_pkg::ADDR_PADS, 16'h1000, 16'h1000);
        @(posedge clk_sys);
        powerfail_sense <= 1'b0;
        repeat (4) @(posedge clk_sys);
        #1;
        chk("irq_fault", 32'(irq), 32'(1'b1));
        $display("test powerfail done");
        wr(4'hD, 16'hFFFF);
        for (int a = 10; a < 16; a++) begin
            rdc(4'(a), 16'hFFFF, 16'h0000);
        end
        rdc(mups_pkg::ADDR_FUNC, 16'hFFFF, 16'(c_func));
        $display("test unmapped done");
        conclude();
    end
endmodule : tb_top
